/* File: include/txen_pkg.sv */
/*
 constants and carriers for the transmit enable control bank.
 assumes a single 250 MHz datapath clock and byte-wide registers.
*/
package txen_pkg;
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFS_TRUNC = 12'h2EA;
   localparam logic [11:0] OFS_SEL = 12'h2F8;
   localparam logic [11:0] OFS_TXEN = 12'h2F9;
   localparam logic [11:0] OFS_OSC = 12'h300;
   localparam logic [7:0] RST_TRUNC = 8'h00;
   localparam logic [7:0] RST_SEL = 8'h03;
   localparam logic [7:0] RST_TXEN = 8'h03;
   localparam logic [7:0] RST_OSC = 8'h00;
   localparam logic [7:0] MASK_TRUNC = 8'h01;
   localparam logic [7:0] MASK_SEL = 8'h0F;
   localparam logic [7:0] MASK_TXEN = 8'h03;
   localparam int BIT_HALF = 0;
   localparam int BIT_SRC_A = 0;
   localparam int BIT_SRC_B = 1;
   localparam int BIT_FAST = 2;
   localparam int BIT_QUIET = 3;
   localparam int QUIET_EXTRA_CLK = 56;
   localparam int OUT_RES = 16;
   localparam int LIMB_RES = 15;
   typedef struct packed {
      logic quiet;
      logic fast;
      logic src_b;
      logic src_a;
   } sel_t;
   typedef struct packed {
      logic mute_in;
      logic safe_code;
      logic enable;
   } chan_ctl_t;
endpackage

/* File: design/txen_ctrl.sv */
/*
 register bank and transmit enable control for two converter channels.
 assumes a plain strobe register port on mclk_i and asynchronous enable balls.
*/
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module txen_ctrl
   import txen_pkg::*;
#(
   parameter int SAMPLE_W = 16,
   parameter int QUIET_DLY = QUIET_EXTRA_CLK
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic datapath_enable_i,
   input wire logic chan_a_enable_ball_i,
   input wire logic chan_b_enable_ball_i,
   input wire logic data_valid_i,
   input wire logic reduced_res_i,
   input wire logic [SAMPLE_W-1:0] sample_a_i,
   input wire logic [SAMPLE_W-1:0] sample_b_i,
   output logic [SAMPLE_W-1:0] sample_a_o,
   output logic [SAMPLE_W-1:0] sample_b_o,
   output logic [1:0] tx_enable_o,
   output logic [1:0] safe_code_o,
   output logic [1:0] mute_in_o,
   output logic clk_gate_o,
   output logic [7:0] oscillator_control_register_o
);
   logic [7:0] trunc_q;
   logic [7:0] sel_q;
   logic [7:0] txen_q;
   logic [7:0] osc_q;
   logic [7:0] rdata_q;
   logic [1:0] ball_m_q;
   logic [1:0] ball_s_q;
   logic gated_q;
   logic mute_q;
   logic [1:0] en_q;
   logic [1:0] safe_q;
   logic [1:0] mutein_q;
   logic [SAMPLE_W-1:0] smp_q [2];
   sel_t sel;
   wire hit_trunc = addr_i == OFS_TRUNC;
   wire hit_sel = addr_i == OFS_SEL;
   wire hit_txen = addr_i == OFS_TXEN;
   wire hit_osc = addr_i == OFS_OSC;
   wire [7:0] rd_mux = hit_trunc ? trunc_q : hit_sel ? sel_q : hit_txen ? txen_q :
                       hit_osc ? osc_q : 8'h00;
   // write enables and next values per register
   wire wr_trunc = wr_i & hit_trunc;
   wire wr_sel = wr_i & hit_sel;
   wire wr_txen = wr_i & hit_txen;
   wire wr_osc = wr_i & hit_osc;
   wire [7:0] trunc_d = wr_trunc ? (wdata_i & MASK_TRUNC) : trunc_q;
   wire [7:0] sel_d = wr_sel ? (wdata_i & MASK_SEL) : sel_q;
   wire [7:0] txen_d = wr_txen ? (wdata_i & MASK_TXEN) : txen_q;
   wire [7:0] osc_d = wr_osc ? wdata_i : osc_q;
   wire [7:0] rdata_d = rd_i ? rd_mux : 8'h00;
   wire [1:0] src_bits = {sel.src_b, sel.src_a};
   wire [1:0] eff_en;
   wire both_low = ~eff_en[0] & ~eff_en[1];
   wire gate_now = ~sel.fast & both_low;
   wire half_on = trunc_q[BIT_HALF] & reduced_res_i & (SAMPLE_W - 1 == LIMB_RES);
   logic [SAMPLE_W-1:0] smp_in [2];
   logic [7:0] dly_q [2];
   wire live_a = en_q[0] & ~mute_q;
   wire live_b = en_q[1] & ~mute_q;
   assign sel = sel_t'(sel_q[3:0]);
   assign smp_in[0] = sample_a_i;
   assign smp_in[1] = sample_b_i;

   // register port, reads answer one cycle later
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         trunc_q <= RST_TRUNC;
         sel_q <= RST_SEL;
         txen_q <= RST_TXEN;
         osc_q <= RST_OSC;
         rdata_q <= 8'h00;
      end else begin
         trunc_q <= trunc_d;
         sel_q <= sel_d;
         txen_q <= txen_d;
         osc_q <= osc_d;
         rdata_q <= rdata_d;
      end
   end

   // ball synchronisers
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ball_m_q <= 2'h0;
         ball_s_q <= 2'h0;
      end else begin
         ball_m_q <= {chan_b_enable_ball_i, chan_a_enable_ball_i};
         ball_s_q <= ball_m_q;
      end
   end

   // clock gating and muting until valid data
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         gated_q <= 1'b0;
         mute_q <= 1'b0;
      end else begin
         gated_q <= gate_now;
         if (gate_now) mute_q <= 1'b1;
         else if (data_valid_i) mute_q <= 1'b0;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_chan
         // source select per channel
         assign eff_en[g] = src_bits[g] ? txen_q[g] : ball_s_q[g];
         wire [SAMPLE_W-1:0] adj = smp_in[g] + SAMPLE_W'(half_on);
         wire live = en_q[g] & ~mute_q;
         always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
               en_q[g] <= 1'b0;
               safe_q[g] <= 1'b0;
               mutein_q[g] <= 1'b0;
               dly_q[g] <= 8'h00;
               smp_q[g] <= '0;
            end else begin
               en_q[g] <= eff_en[g];
               mutein_q[g] <= sel.quiet & ~live;
               if (live) dly_q[g] <= 8'h00;
               else if (sel.quiet && dly_q[g] < 8'(QUIET_DLY)) dly_q[g] <= dly_q[g] + 8'h01;
               safe_q[g] <= ~live & ~sel.quiet;
               if (live) smp_q[g] <= adj;
               else if (!sel.quiet) smp_q[g] <= '0;
               else smp_q[g] <= '0;
            end
         end
      end
   endgenerate

   // outputs
   assign rdata_o = rdata_q;
   assign sample_a_o = smp_q[0];
   assign sample_b_o = smp_q[1];
   assign tx_enable_o = en_q;
   assign safe_code_o = safe_q;
   assign mute_in_o = mutein_q;
   assign clk_gate_o = gated_q;
   assign oscillator_control_register_o = osc_q;

   AST_SRC_REG: assert property (@(posedge mclk_i) disable iff (rst_i)
      sel.src_a |=> tx_enable_o[0] == $past(txen_q[0]))
      else $error("channel a not following register bit");
   AST_SRC_BALL: assert property (@(posedge mclk_i) disable iff (rst_i)
      !sel.src_a && $stable(sel_q) |=> tx_enable_o[0] == $past(ball_s_q[0]))
      else $error("channel a not following ball");
   AST_SRC_B: assert property (@(posedge mclk_i) disable iff (rst_i)
      sel.src_b |=> tx_enable_o[1] == $past(txen_q[1]))
      else $error("channel b not following register bit");
   AST_GATE: assert property (@(posedge mclk_i) disable iff (rst_i)
      gate_now |=> clk_gate_o)
      else $error("clocks not gated");
   AST_NOGATE: assert property (@(posedge mclk_i) disable iff (rst_i)
      sel.fast |=> !clk_gate_o)
      else $error("gating in fast mode");
   AST_QUIET: assert property (@(posedge mclk_i) disable iff (rst_i)
      sel.quiet && !tx_enable_o[0] |=> mute_in_o[0] && !safe_code_o[0])
      else $error("quiet disable not muting");
   AST_SAFE: assert property (@(posedge mclk_i) disable iff (rst_i)
      !sel.quiet && !tx_enable_o[0] |=> safe_code_o[0] && sample_a_o == '0)
      else $error("safe code missing");
   AST_SYNC: assert property (@(posedge mclk_i) disable iff (rst_i)
      ball_s_q == $past(ball_m_q))
      else $error("ball synchroniser broken");
   AST_HALF: assert property (@(posedge mclk_i) disable iff (rst_i)
      live_a && half_on |=> sample_a_o == $past(sample_a_i) + SAMPLE_W'(1))
      else $error("half step offset missing");

   // register port checks
   AST_RD_TRUNC: assert property (@(posedge mclk_i) disable iff (rst_i)
      rd_i && hit_trunc
      |=> rdata_o == $past(trunc_q))
      else $error("truncation register read wrong");
   AST_RD_SEL: assert property (@(posedge mclk_i) disable iff (rst_i)
      rd_i && hit_sel
      |=> rdata_o == $past(sel_q))
      else $error("source select register read wrong");
   AST_RD_TXEN: assert property (@(posedge mclk_i) disable iff (rst_i)
      rd_i && hit_txen
      |=> rdata_o == $past(txen_q))
      else $error("enable register read wrong");
   AST_WR_TRUNC: assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_trunc
      |=> trunc_q == ($past(wdata_i) & MASK_TRUNC))
      else $error("truncation register write lost");
   AST_WR_SEL: assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_sel
      |=> sel_q == ($past(wdata_i) & MASK_SEL))
      else $error("source select register write lost");
   AST_WR_TXEN: assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_txen
      |=> txen_q == ($past(wdata_i) & MASK_TXEN))
      else $error("enable register write lost");

   // second channel checks
   AST_SRC_BALL_B: assert property (@(posedge mclk_i) disable iff (rst_i)
      !sel.src_b && $stable(sel_q)
      |=> tx_enable_o[1] == $past(ball_s_q[1]))
      else $error("channel b not following ball");
   AST_QUIET_B: assert property (@(posedge mclk_i) disable iff (rst_i)
      sel.quiet && !tx_enable_o[1]
      |=> mute_in_o[1] && !safe_code_o[1])
      else $error("quiet disable not muting channel b");
   AST_SAFE_B: assert property (@(posedge mclk_i) disable iff (rst_i)
      !sel.quiet && !tx_enable_o[1]
      |=> safe_code_o[1] && sample_b_o == '0)
      else $error("safe code missing on channel b");
   AST_HALF_B: assert property (@(posedge mclk_i) disable iff (rst_i)
      live_b && half_on
      |=> sample_b_o == $past(sample_b_i) + SAMPLE_W'(1))
      else $error("half step offset missing on channel b");

   // sample path checks
   AST_NOHALF: assert property (@(posedge mclk_i) disable iff (rst_i)
      live_a && !half_on
      |=> sample_a_o == $past(sample_a_i))
      else $error("channel a sample altered");
   AST_NOHALF_B: assert property (@(posedge mclk_i) disable iff (rst_i)
      live_b && !half_on
      |=> sample_b_o == $past(sample_b_i))
      else $error("channel b sample altered");
   AST_LIVE_A: assert property (@(posedge mclk_i) disable iff (rst_i)
      live_a
      |=> !safe_code_o[0] && !mute_in_o[0])
      else $error("channel a disabled while live");
   AST_LIVE_B: assert property (@(posedge mclk_i) disable iff (rst_i)
      live_b
      |=> !safe_code_o[1] && !mute_in_o[1])
      else $error("channel b disabled while live");
   AST_DIS_ZERO: assert property (@(posedge mclk_i) disable iff (rst_i)
      !live_a
      |=> sample_a_o == '0)
      else $error("channel a output not cleared");
   AST_DIS_ZERO_B: assert property (@(posedge mclk_i) disable iff (rst_i)
      !live_b
      |=> sample_b_o == '0)
      else $error("channel b output not cleared");
   AST_MUTEIN_QUIET: assert property (@(posedge mclk_i) disable iff (rst_i)
      !sel.quiet
      |=> mute_in_o == 2'b00)
      else $error("matching input muted without quiet disable");
   AST_SAFE_QUIET: assert property (@(posedge mclk_i) disable iff (rst_i)
      sel.quiet
      |=> safe_code_o == 2'b00)
      else $error("safe code used with quiet disable");

   // gating and mute checks
   AST_MUTE_SET: assert property (@(posedge mclk_i) disable iff (rst_i)
      gate_now
      |=> mute_q)
      else $error("mute not set while gated");
   AST_MUTE_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
      mute_q && !data_valid_i && !gate_now
      |=> mute_q)
      else $error("mute released before valid data");
   AST_MUTE_REL: assert property (@(posedge mclk_i) disable iff (rst_i)
      !gate_now && data_valid_i
      |=> !mute_q)
      else $error("mute kept after valid data");
   AST_MUTED_OUT: assert property (@(posedge mclk_i) disable iff (rst_i)
      mute_q
      |=> sample_a_o == '0 && sample_b_o == '0)
      else $error("samples passed while muted");
   AST_MUTE_GATED: assert property (@(posedge mclk_i) disable iff (rst_i)
      clk_gate_o
      |-> mute_q)
      else $error("gated without mute");
   AST_UNGATE: assert property (@(posedge mclk_i) disable iff (rst_i)
      !gate_now
      |=> !clk_gate_o)
      else $error("clocks gated with an enable high");
   AST_GATE_BOTH: assert property (@(posedge mclk_i) disable iff (rst_i)
      clk_gate_o
      |-> $past(both_low))
      else $error("gated while an enable was high");
   AST_GATE_FAST: assert property (@(posedge mclk_i) disable iff (rst_i)
      clk_gate_o
      |-> !$past(sel_q[BIT_FAST]))
      else $error("gated although fast enable was set");
   AST_INDEP: assert property (@(posedge mclk_i) disable iff (rst_i)
      sel.fast && eff_en == 2'b01
      |=> tx_enable_o == 2'b01)
      else $error("channel enables not independent");

   // quiet latency counter checks
   AST_QDLY_CAP: assert property (@(posedge mclk_i) disable iff (rst_i)
      1'b1
      |-> dly_q[0] <= 8'(QUIET_DLY))
      else $error("quiet latency counter overran");
   AST_QDLY_CLR: assert property (@(posedge mclk_i) disable iff (rst_i)
      live_a
      |=> dly_q[0] == 8'h00)
      else $error("quiet latency counter not cleared");
   AST_QDLY_RUN: assert property (@(posedge mclk_i) disable iff (rst_i)
      sel.quiet && !live_a && dly_q[0] < 8'(QUIET_DLY)
      |=> dly_q[0] == $past(dly_q[0]) + 8'h01)
      else $error("quiet latency counter stalled");

   // ball synchroniser checks
   AST_SYNC_MA: assert property (@(posedge mclk_i) disable iff (rst_i)
      1'b1
      |-> ball_m_q[0] == $past(chan_a_enable_ball_i))
      else $error("channel a ball first stage broken");
   AST_SYNC_MB: assert property (@(posedge mclk_i) disable iff (rst_i)
      1'b1
      |-> ball_m_q[1] == $past(chan_b_enable_ball_i))
      else $error("channel b ball first stage broken");

   // main scenarios
   COV_GATE: cover property (@(posedge mclk_i) disable iff (rst_i) clk_gate_o ##1 !clk_gate_o);
   COV_MUTE_REL: cover property (@(posedge mclk_i) disable iff (rst_i) mute_q ##1 !mute_q);
   COV_QUIET: cover property (@(posedge mclk_i) disable iff (rst_i) mute_in_o[0]);
   COV_BALL: cover property (@(posedge mclk_i) disable iff (rst_i) !sel.src_a && tx_enable_o[0]);
endmodule
`default_nettype wire

/* File: test/txen_ball_host.sv */
/*
 host logic model driving the two transmit enable balls.
 assumes level_i comes from the bench; balls move away from the clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module txen_ball_host (
   input wire logic mclk_i,
   input wire logic level_i,
   output logic chan_a_o = 1'b0,
   output logic chan_b_o = 1'b0
);
   // both balls carry one level, skewed so the design sees them asynchronously
   always @(posedge mclk_i) begin
      chan_a_o <= #1.3 level_i;
      chan_b_o <= #1.7 level_i;
   end
endmodule
`default_nettype wire

/* File: test/tb_txen_ctrl.sv */
/*
 self-checking testbench for the transmit enable control bank.
 assumes the ball host model and a 250 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_txen_ctrl;
   import txen_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [ADDR_W-1:0] addr_i = '0;
   logic [7:0] wdata_i = '0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic res_lo = 1'b0;
   logic level = 1'b0;
   logic dvalid = 1'b1;
   logic [15:0] samp = 16'h1000;
   logic [7:0] rdata_o, osc_o;
   logic [15:0] sa_o, sb_o;
   logic [1:0] txe_o, safe_o, mute_o;
   logic gate_o, ball_a, ball_b;
   int n_fail = 0;
   int tests_run = 0;
   always #2 mclk_i = ~mclk_i;
   txen_ball_host i_host (.mclk_i(mclk_i), .level_i(level), .chan_a_o(ball_a), .chan_b_o(ball_b));
   txen_ctrl i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .datapath_enable_i(1'b0),
      .chan_a_enable_ball_i(ball_a), .chan_b_enable_ball_i(ball_b), .data_valid_i(dvalid),
      .reduced_res_i(res_lo), .sample_a_i(samp), .sample_b_i(samp), .sample_a_o(sa_o),
      .sample_b_o(sb_o), .tx_enable_o(txe_o), .safe_code_o(safe_o), .mute_in_o(mute_o),
      .clk_gate_o(gate_o), .oscillator_control_register_o(osc_o));
   task automatic end_of_test;
      if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, exp);
   endtask
   initial begin
      #20000;
      n_fail++;
      end_of_test();
   end
   initial begin
      repeat (20) @(posedge mclk_i);
      rst_i <= 1'b0;
      settle(2);
      chk(txe_o, 2'b11);
      chk(gate_o, 1'b0);
      rdc(OFS_TRUNC, RST_TRUNC);
      rdc(OFS_SEL, RST_SEL);
      rdc(OFS_TXEN, RST_TXEN);
      rdc(OFS_OSC, RST_OSC);
      rdc(12'h2FB, 8'h00);
      wr(OFS_TXEN, 8'h00);
      settle(2);
      chk(txe_o, 2'b00);
      chk(safe_o, 2'b11);
      chk(gate_o, 1'b1);
      chk(sa_o, 16'h0000);
      chk(sb_o, 16'h0000);
      @(posedge mclk_i);
      dvalid <= 1'b0;
      wr(OFS_TXEN, 8'h03);
      settle(2);
      chk(txe_o, 2'b11);
      chk(gate_o, 1'b0);
      chk(sa_o, 16'h0000);
      @(posedge mclk_i);
      dvalid <= 1'b1;
      settle(2);
      chk(sa_o, samp);
      chk(sb_o, samp);
      wr(OFS_TXEN, 8'h00);
      settle(2);
      wr(OFS_SEL, 8'h07);
      settle(2);
      chk(gate_o, 1'b0);
      wr(OFS_SEL, 8'h0F);
      settle(QUIET_EXTRA_CLK + 4);
      chk(mute_o, 2'b11);
      wr(OFS_SEL, 8'h04);
      level <= 1'b1;
      settle(4);
      chk(txe_o, 2'b11);
      wr(OFS_TXEN, 8'h03);
      level <= 1'b0;
      settle(4);
      chk(txe_o, 2'b00);
      wr(OFS_SEL, 8'h07);
      settle(2);
      chk(txe_o, 2'b11);
      wr(OFS_TRUNC, 8'h01);
      settle(4);
      chk(sa_o, samp);
      @(posedge mclk_i);
      res_lo <= 1'b1;
      settle(4);
      chk(sa_o, samp + 16'(1 << (OUT_RES - LIMB_RES - 1)));
      chk(sb_o, samp + 16'(1 << (OUT_RES - LIMB_RES - 1)));
      wr(OFS_OSC, 8'hA5);
      settle(2);
      chk(osc_o, 8'hA5);
      rdc(OFS_OSC, 8'hA5);
      wr(OFS_TRUNC, 8'hFF);
      rdc(OFS_TRUNC, MASK_TRUNC);
      end_of_test();
   end
endmodule
`default_nettype wire
